/* File: core/bfs_pkg.sv */
package bfs_pkg;

	// timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int SW_PERIOD_NS  = 2000;
	localparam int SW_CYC        = SW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MAX_DUTY_PCT  = 94;
	// longest high-side time rounds down
	localparam int MAX_ON_CYC    = SW_CYC * MAX_DUTY_PCT / 100;
	localparam int LS_BLANK_NS   = 150;
	localparam int LS_BLANK_CYC  =
		(LS_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_BLANK_US  = 20;
	localparam int FLT_BLANK_CYC =
		(FLT_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// sequencing counts; hiccup in soft-start durations, trips in events, the rest in switching cycles
	localparam int HICCUP_MULT     = 4;
	localparam int OC_TRIP_COUNT   = 3;
	localparam int OC_CLEAR_CYCLES = 7;
	localparam int SS_CYC_DEFAULT  = 500;

	// widths
	localparam int CYC_W = 8;
	localparam int BLK_W = 12;
	localparam int LSB_W = 5;
	localparam int OCC_W = 2;
	localparam int BKP_W = 3;
	localparam int SS_W  = 16;
	localparam int HIC_W = SS_W + 2;

	// register port
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 2'h0;
	localparam logic [ADDR_W-1:0] REG_SS_CYCLES = 2'h1;
	localparam logic [DATA_W-1:0] RD_ZERO       = 16'h0000;

	// status field positions
	localparam int STB_PG_OK   = 0;
	localparam int STB_OC_SKIP = 1;
	localparam int STB_OV      = 2;
	localparam int STB_UV      = 3;
	localparam int STB_OT      = 4;
	localparam int STB_TSD     = 5;
	localparam int STB_OCCNT   = 6;
	localparam int STB_STATE   = 8;

	typedef enum logic [2:0] {
		BFS_OFF,
		BFS_SOFT,
		BFS_RUN,
		BFS_OVP,
		BFS_HICCUP,
		BFS_OTEMP,
		BFS_TSD
	} bfs_state_t;

	// digital flags from the analog side, all asynchronous
	typedef struct packed {
		logic deep_disable;
		logic en_cmp;
		logic vin_lockout;
		logic vcc_lockout;
		logic fb_above_reg;
		logic fb_ov_cmp;
		logic fb_uv_cmp;
		logic external_overtemp_input;
		logic internal_thermal_shutdown;
		logic lowside_overcurrent_detect;
		logic current_set_resistor_present;
		logic pwm_cmp;
		logic hs_gate_off;
		logic ls_gate_off;
	} bfs_pins_t;

	localparam int PIN_W = $bits(bfs_pins_t);

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bfs_bus_req_t;

endpackage

/* File: core/bfs_sync.sv */
// two-stage synchroniser, one chain per bit
module bfs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_bit
			logic meta_ff;
			logic sync_ff;

			// first stage feeds only the second stage; reset to ones so
			// deep disable and the lockouts read as asserted until real
			// samples arrive, instead of a false release after reset
			always_ff @(posedge clk_sys)
			begin
				if (!reset_n)
				begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
				end
				else
				begin
					meta_ff <= d[gi];
					sync_ff <= meta_ff;
				end
			end

			assign q[gi] = sync_ff;
		end
	endgenerate

endmodule

/* File: core/bfs_buck_fault_sequencer.sv */
// Notes on behaviour
// - high side on at most 94% of each switching period
// - during soft-start only the overcurrent detection is acted on
// - soft-start begins once enabled and both supply lockouts released
// - deep disable holds all logic but the register port inactive and drivers off
// - pre-biased output above regulation holds switching until it falls back
// - adaptive dead time: a switch turns on only once the other is off
// - hiccup turns both switches off and pulls power good low
// - hiccup waits four soft-start durations then restarts soft-start
// - external overtemperature stops switching, both switches off
// - external overtemperature clearing starts a new soft-start
// - overvoltage held 20 us latches fault: high off, low on, pg low
// - after overvoltage keep low side on until undervoltage, then hiccup
// - undervoltage held over 20 us latches fault and enters hiccup
// - low-side overcurrent sampled only 150 ns after low side turns on
// - no current-set resistor selects the fixed 300 mV threshold
// - after overcurrent skip high pulses until current falls below trip
// - three consecutive overcurrent events enter hiccup
// - seven clean switching cycles clear the overcurrent counter
// - each overcurrent detection restarts the backup counter
// - thermal shutdown: both off, comp clamped; on clearing release clamp and soft-start
// - power good released only between undervoltage and overvoltage
// - power good low on any fault or during soft-start
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
module bfs_buck_fault_sequencer #(
	parameter int SS_CYC_RESET = bfs_pkg::SS_CYC_DEFAULT
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset_n,
	input  wire bfs_pkg::bfs_pins_t           pins_in,
	input  wire bfs_pkg::bfs_bus_req_t        bus_req,
	output logic      [bfs_pkg::DATA_W-1:0]   rd_data,
	output logic                              high_side_switch,
	output logic                              low_side_switch,
	output logic                              power_good_out_o,
	output logic                              power_good_out_oe,
	output logic                              oc_threshold_fixed,
	output logic                              comp_clamp
);

	localparam int HW = bfs_pkg::HIC_W;
	localparam int SW = bfs_pkg::SS_W;
	localparam int CW = bfs_pkg::CYC_W;
	localparam int BW = bfs_pkg::BLK_W;
	localparam int LW = bfs_pkg::LSB_W;
	localparam int OW = bfs_pkg::OCC_W;
	localparam int KW = bfs_pkg::BKP_W;
	localparam int DW = bfs_pkg::DATA_W;

	localparam logic [CW-1:0] CYC_LAST   = CW'(bfs_pkg::SW_CYC - 1);
	localparam logic [CW-1:0] ON_LAST    = CW'(bfs_pkg::MAX_ON_CYC - 1);
	localparam logic [LW-1:0] LS_BLANK   = LW'(bfs_pkg::LS_BLANK_CYC);
	localparam logic [BW-1:0] FLT_BLANK  = BW'(bfs_pkg::FLT_BLANK_CYC);
	localparam logic [OW-1:0] OC_LAST    = OW'(bfs_pkg::OC_TRIP_COUNT - 1);
	localparam logic [KW-1:0] BKP_LAST   = KW'(bfs_pkg::OC_CLEAR_CYCLES - 1);
	localparam logic [HW-1:0] HIC_MULT   = HW'(bfs_pkg::HICCUP_MULT);
	localparam logic [SW-1:0] SS_RST_VAL = SW'(SS_CYC_RESET);

	logic [bfs_pkg::PIN_W-1:0] pin_raw;
	logic [bfs_pkg::PIN_W-1:0] pin_q;
	bfs_pkg::bfs_pins_t        pin_s;
	bfs_pkg::bfs_state_t       state_ff;
	bfs_pkg::bfs_state_t       nxt_state;

	logic          hold;
	logic          supply_ok;
	logic [CW-1:0] cyc_cnt_ff;
	logic          cyc_end;
	logic          sw_active;
	logic          hs_req_ff;
	logic          ls_want;
	logic          hs_ff;
	logic          ls_ff;
	logic [LW-1:0] ls_on_cnt_ff;
	logic          oc_sample;
	logic          oc_trip;
	logic          oc_skip_ff;
	logic          oc_seen_ff;
	logic          trip_now;
	logic [OW-1:0] oc_cnt_ff;
	logic [KW-1:0] bkp_cnt_ff;
	logic          oc_hiccup;
	logic [BW-1:0] ov_cnt_ff;
	logic [BW-1:0] uv_cnt_ff;
	logic          ov_fault;
	logic          uv_fault;
	logic          prebias_ff;
	logic [HW-1:0] seq_cnt_ff;
	logic [HW-1:0] hic_target;
	logic          ss_done;
	logic          hic_done;
	logic [SW-1:0] ss_cycles_ff;
	logic          pg_oe_ff;
	logic          oc_fixed_ff;
	logic          clamp_ff;
	logic [DW-1:0] rd_data_ff;
	logic [DW-1:0] status_word;

	// every analog flag is asynchronous to clk_sys
	assign pin_raw = pins_in;

	bfs_sync #(
		.WIDTH (bfs_pkg::PIN_W)
	) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.d       (pin_raw),
		.q       (pin_q)
	);

	assign pin_s = pin_q;

	// deep disable acts as a second synchronous reset for the sequencer
	assign hold      = !reset_n || pin_s.deep_disable;
	assign supply_ok = pin_s.en_cmp && !pin_s.vin_lockout
		&& !pin_s.vcc_lockout;

	// switching period counter; one wrap is one switching cycle
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			cyc_cnt_ff <= '0;
		else if (cyc_cnt_ff == CYC_LAST)
			cyc_cnt_ff <= '0;
		else
			cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
	end

	assign cyc_end   = (cyc_cnt_ff == CYC_LAST);
	assign sw_active = (state_ff == bfs_pkg::BFS_RUN)
		|| (state_ff == bfs_pkg::BFS_SOFT && !prebias_ff);

	// high-side request: set at the cycle boundary, cut by the comparator
	always_ff @(posedge clk_sys)
	begin
		if (hold || !sw_active)
			hs_req_ff <= 1'b0;
		else if (hs_req_ff && (!pin_s.pwm_cmp || cyc_cnt_ff == ON_LAST))
			hs_req_ff <= 1'b0;
		else if (cyc_end && !oc_skip_ff && !oc_trip)
			hs_req_ff <= 1'b1;
	end

	// overvoltage discharge keeps the low side on with the high side off
	assign ls_want = (state_ff == bfs_pkg::BFS_OVP)
		|| (sw_active && !hs_req_ff);

	// each driver waits for the sensed gate of the other to be off;
	// a fault state cuts the high side on its first edge, not one later
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			hs_ff <= 1'b0;
		else
			hs_ff <= hs_req_ff && sw_active && pin_s.ls_gate_off
				&& !ls_ff;
	end

	// low side also checks the request so both never switch on together
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			ls_ff <= 1'b0;
		else
			ls_ff <= ls_want && !hs_req_ff && pin_s.hs_gate_off
				&& !hs_ff;
	end

	// low-side conduction timer for the overcurrent blanking window
	always_ff @(posedge clk_sys)
	begin
		if (hold || !ls_ff)
			ls_on_cnt_ff <= '0;
		else if (ls_on_cnt_ff != LS_BLANK)
			ls_on_cnt_ff <= ls_on_cnt_ff + 1'b1;
	end

	// the switch-node ring right after turn-on would false trip
	assign oc_sample = ls_ff && (ls_on_cnt_ff == LS_BLANK);
	assign oc_trip   = oc_sample && pin_s.lowside_overcurrent_detect;

	// pulse skipping: set wins over the clearing sample
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			oc_skip_ff <= 1'b0;
		else if (oc_trip)
			oc_skip_ff <= 1'b1;
		else if (oc_sample)
			oc_skip_ff <= 1'b0;
	end

	// remembers a trip anywhere inside the current switching cycle
	always_ff @(posedge clk_sys)
	begin
		if (hold || cyc_end)
			oc_seen_ff <= 1'b0;
		else if (oc_trip)
			oc_seen_ff <= 1'b1;
	end

	assign trip_now  = oc_seen_ff || oc_trip;
	assign oc_hiccup = cyc_end && trip_now && (oc_cnt_ff == OC_LAST);

	// event counter and its backup clear counter, both per switching cycle
	always_ff @(posedge clk_sys)
	begin
		if (hold || !(state_ff == bfs_pkg::BFS_SOFT
			|| state_ff == bfs_pkg::BFS_RUN))
		begin
			oc_cnt_ff  <= '0;
			bkp_cnt_ff <= '0;
		end
		else if (cyc_end && trip_now)
		begin
			if (oc_cnt_ff != OC_LAST)
				oc_cnt_ff <= oc_cnt_ff + 1'b1;
			bkp_cnt_ff <= '0;
		end
		else if (cyc_end && bkp_cnt_ff == BKP_LAST)
		begin
			oc_cnt_ff  <= '0;
			bkp_cnt_ff <= '0;
		end
		else if (cyc_end)
			bkp_cnt_ff <= bkp_cnt_ff + 1'b1;
	end

	// overvoltage blanking; only counts in regulation, so soft-start
	// never sees it
	always_ff @(posedge clk_sys)
	begin
		if (hold || state_ff != bfs_pkg::BFS_RUN || !pin_s.fb_ov_cmp)
			ov_cnt_ff <= '0;
		else if (ov_cnt_ff != FLT_BLANK)
			ov_cnt_ff <= ov_cnt_ff + 1'b1;
	end

	// undervoltage blanking, same window as overvoltage
	always_ff @(posedge clk_sys)
	begin
		if (hold || state_ff != bfs_pkg::BFS_RUN || !pin_s.fb_uv_cmp)
			uv_cnt_ff <= '0;
		else if (uv_cnt_ff != FLT_BLANK)
			uv_cnt_ff <= uv_cnt_ff + 1'b1;
	end

	assign ov_fault = (ov_cnt_ff == FLT_BLANK);
	assign uv_fault = (uv_cnt_ff == FLT_BLANK);

	// pre-bias hold is sampled as soft-start is entered
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			prebias_ff <= 1'b0;
		else if (state_ff != bfs_pkg::BFS_SOFT
			&& nxt_state == bfs_pkg::BFS_SOFT)
			prebias_ff <= pin_s.fb_above_reg;
		else if (!pin_s.fb_above_reg)
			prebias_ff <= 1'b0;
	end

	// soft-start and hiccup timer in switching cycles, cleared per state
	always_ff @(posedge clk_sys)
	begin
		if (hold || nxt_state != state_ff)
			seq_cnt_ff <= '0;
		else if (cyc_end && !(state_ff == bfs_pkg::BFS_SOFT && prebias_ff))
			seq_cnt_ff <= seq_cnt_ff + 1'b1;
	end

	assign hic_target = HW'(ss_cycles_ff) * HIC_MULT;
	assign ss_done    = (seq_cnt_ff >= HW'(ss_cycles_ff));
	assign hic_done   = (seq_cnt_ff >= hic_target);

	// sequencer; losing enable or a supply drops to off from anywhere
	always_comb
	begin
		nxt_state = state_ff;
		if (!supply_ok)
			nxt_state = bfs_pkg::BFS_OFF;
		else
		begin
			unique case (state_ff)
				bfs_pkg::BFS_OFF:
					nxt_state = bfs_pkg::BFS_SOFT;
				bfs_pkg::BFS_SOFT:
				begin
					if (oc_hiccup)
						nxt_state = bfs_pkg::BFS_HICCUP;
					else if (ss_done)
						nxt_state = bfs_pkg::BFS_RUN;
				end
				bfs_pkg::BFS_RUN:
				begin
					if (oc_hiccup)
						nxt_state = bfs_pkg::BFS_HICCUP;
					else if (pin_s.internal_thermal_shutdown)
						nxt_state = bfs_pkg::BFS_TSD;
					else if (ov_fault)
						nxt_state = bfs_pkg::BFS_OVP;
					else if (uv_fault)
						nxt_state = bfs_pkg::BFS_HICCUP;
					else if (pin_s.external_overtemp_input)
						nxt_state = bfs_pkg::BFS_OTEMP;
				end
				bfs_pkg::BFS_OVP:
				begin
					if (pin_s.fb_uv_cmp)
						nxt_state = bfs_pkg::BFS_HICCUP;
				end
				bfs_pkg::BFS_HICCUP:
				begin
					if (hic_done)
						nxt_state = bfs_pkg::BFS_SOFT;
				end
				bfs_pkg::BFS_OTEMP:
				begin
					if (!pin_s.external_overtemp_input)
						nxt_state = bfs_pkg::BFS_SOFT;
				end
				bfs_pkg::BFS_TSD:
				begin
					if (!pin_s.internal_thermal_shutdown)
						nxt_state = bfs_pkg::BFS_SOFT;
				end
				default:
					nxt_state = bfs_pkg::BFS_OFF;
			endcase
		end
	end

	// hiccup, off, overtemperature and shutdown leave sw_active low,
	// so both drivers fall on entry
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			state_ff <= bfs_pkg::BFS_OFF;
		else
			state_ff <= nxt_state;
	end

	// power good pulls low unless regulating cleanly inside the window
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			pg_oe_ff <= 1'b1;
		else
			pg_oe_ff <= !(state_ff == bfs_pkg::BFS_RUN
				&& nxt_state == bfs_pkg::BFS_RUN
				&& !pin_s.fb_ov_cmp && !pin_s.fb_uv_cmp
				&& !oc_skip_ff && !pin_s.external_overtemp_input
				&& !pin_s.internal_thermal_shutdown);
	end

	// threshold select follows resistor detection
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			oc_fixed_ff <= 1'b0;
		else
			oc_fixed_ff <= !pin_s.current_set_resistor_present;
	end

	// compensation clamp held through shutdown so restart begins at valley
	always_ff @(posedge clk_sys)
	begin
		if (hold)
			clamp_ff <= 1'b0;
		else
			clamp_ff <= (state_ff == bfs_pkg::BFS_TSD);
	end

	// soft-start length is software-set and also sets the hiccup wait
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			ss_cycles_ff <= SS_RST_VAL;
		else if (bus_req.wr && bus_req.addr == bfs_pkg::REG_SS_CYCLES)
			ss_cycles_ff <= bus_req.wdata;
	end

	// live status word
	always_comb
	begin
		status_word = bfs_pkg::RD_ZERO;
		status_word[bfs_pkg::STB_PG_OK]   = !pg_oe_ff;
		status_word[bfs_pkg::STB_OC_SKIP] = oc_skip_ff;
		status_word[bfs_pkg::STB_OV]      = (state_ff == bfs_pkg::BFS_OVP);
		status_word[bfs_pkg::STB_UV]      = uv_fault;
		status_word[bfs_pkg::STB_OT]      = (state_ff == bfs_pkg::BFS_OTEMP);
		status_word[bfs_pkg::STB_TSD]     = (state_ff == bfs_pkg::BFS_TSD);
		status_word[bfs_pkg::STB_OCCNT +: OW] = oc_cnt_ff;
		status_word[bfs_pkg::STB_STATE +: 3]  = state_ff;
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !bus_req.rd)
			rd_data_ff <= bfs_pkg::RD_ZERO;
		else if (bus_req.addr == bfs_pkg::REG_STATUS)
			rd_data_ff <= status_word;
		else if (bus_req.addr == bfs_pkg::REG_SS_CYCLES)
			rd_data_ff <= ss_cycles_ff;
		else
			rd_data_ff <= bfs_pkg::RD_ZERO;
	end

	// open-drain power good never drives high
	assign power_good_out_o   = 1'b0;
	assign power_good_out_oe  = pg_oe_ff;
	assign high_side_switch   = hs_ff;
	assign low_side_switch    = ls_ff;
	assign oc_threshold_fixed = oc_fixed_ff;
	assign comp_clamp         = clamp_ff;
	assign rd_data            = rd_data_ff;

endmodule

/* File: testbench/bfs_assertions.sv */
// port-level checks, bound into the sequencer
module bfs_assertions #(
	parameter int SS_CYC_RESET = bfs_pkg::SS_CYC_DEFAULT
) (
	input wire logic                       clk_sys,
	input wire logic                       reset_n,
	input wire bfs_pkg::bfs_pins_t         pins_in,
	input wire bfs_pkg::bfs_bus_req_t      bus_req,
	input wire logic [bfs_pkg::DATA_W-1:0] rd_data,
	input wire logic                       high_side_switch,
	input wire logic                       low_side_switch,
	input wire logic                       power_good_out_o,
	input wire logic                       power_good_out_oe,
	input wire logic                       oc_threshold_fixed,
	input wire logic                       comp_clamp
);
	timeunit 1ns;
	timeprecision 1ps;
	int hs_run_ff;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// length of the present high-side pulse, a repetition would be too long
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !high_side_switch)
			hs_run_ff <= 0;
		else
			hs_run_ff <= hs_run_ff + 1;
	end

	property p_no_overlap;
		!(high_side_switch && low_side_switch);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both switches on");
	property p_hs_dead;
		$rose(high_side_switch) |->
			!$past(low_side_switch) && $past(pins_in.ls_gate_off, 3);
	endproperty
	a_hs_dead: assert property (p_hs_dead)
		else $error("high side on before low side sensed off");
	property p_ls_dead;
		$rose(low_side_switch) |->
			!$past(high_side_switch) && $past(pins_in.hs_gate_off, 3);
	endproperty
	a_ls_dead: assert property (p_ls_dead)
		else $error("low side on before high side sensed off");
	property p_max_duty;
		hs_run_ff <= bfs_pkg::MAX_ON_CYC;
	endproperty
	a_max_duty: assert property (p_max_duty)
		else $error("high side pulse too long");
	property p_deep_off;
		pins_in.deep_disable [*4] |->
			!high_side_switch && !low_side_switch && power_good_out_oe;
	endproperty
	a_deep_off: assert property (p_deep_off)
		else $error("drivers active in deep disable");
	property p_fixed;
		(!pins_in.current_set_resistor_present && !pins_in.deep_disable) [*5]
			|-> oc_threshold_fixed;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed threshold not selected");
	property p_pg_window;
		(pins_in.fb_ov_cmp || pins_in.fb_uv_cmp) [*5] |-> power_good_out_oe;
	endproperty
	a_pg_window: assert property (p_pg_window)
		else $error("power good released out of window");
	property p_pg_fault;
		(pins_in.external_overtemp_input
			|| pins_in.internal_thermal_shutdown) [*5] |-> power_good_out_oe;
	endproperty
	a_pg_fault: assert property (p_pg_fault)
		else $error("power good released during overtemperature");
	property p_clamp;
		comp_clamp |-> !high_side_switch && !low_side_switch;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("switching while clamped");
	property p_rd_idle;
		!$past(bus_req.rd) |-> rd_data == bfs_pkg::RD_ZERO;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
endmodule

bind bfs_buck_fault_sequencer bfs_assertions #(
	.SS_CYC_RESET(SS_CYC_RESET)
) u_bfs_assertions (
	.clk_sys(clk_sys), .reset_n(reset_n), .pins_in(pins_in),
	.bus_req(bus_req), .rd_data(rd_data),
	.high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
	.power_good_out_o(power_good_out_o),
	.power_good_out_oe(power_good_out_oe),
	.oc_threshold_fixed(oc_threshold_fixed), .comp_clamp(comp_clamp)
);

/* File: testbench/bfs_analog_model.sv */
// gate sensing, pwm comparator and low-side current comparator
module bfs_analog_model (
	input  wire logic       clk_sys,
	input  wire logic       high_side_switch,
	input  wire logic       low_side_switch,
	input  wire logic       slow,
	input  wire logic [7:0] duty,
	input  wire logic [1:0] oc_mode,
	output logic            hs_gate_off,
	output logic            ls_gate_off,
	output logic            pwm_cmp,
	output logic            lowside_overcurrent_detect
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hs_q = 1'b0;
	logic ls_q = 1'b0;
	int   hs_n = 0;
	int   ls_n = 0;
	int   dly;

	// clocks each drive has held its level
	always_ff @(posedge clk_sys)
	begin
		hs_q <= high_side_switch;
		ls_q <= low_side_switch;
		hs_n <= (high_side_switch != hs_q) ? 0 : hs_n + 1;
		ls_n <= (low_side_switch != ls_q) ? 0 : ls_n + 1;
	end

	// slow gates stretch the dead time the sequencer must wait out
	assign dly = slow ? 4 : 1;
	assign hs_gate_off = !high_side_switch && !hs_q && hs_n >= dly;
	assign ls_gate_off = !low_side_switch && !ls_q && ls_n >= dly;
	assign pwm_cmp = !(high_side_switch && hs_q && hs_n >= int'(duty));
	// mode 1 trips only inside the blanking window
	assign lowside_overcurrent_detect = low_side_switch && ls_q
		&& (oc_mode == 2'h2 || (oc_mode == 2'h1 && ls_n < 10));
endmodule

/* File: testbench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SS_RUN = 3;
	localparam int HIC = bfs_pkg::HICCUP_MULT * SS_RUN * bfs_pkg::SW_CYC;
	logic                       clk_sys = 1'b0;
	logic                       reset_n = 1'b0;
	bfs_pkg::bfs_pins_t         drv;
	bfs_pkg::bfs_pins_t         pins;
	bfs_pkg::bfs_bus_req_t      bus;
	logic [bfs_pkg::DATA_W-1:0] rd_data;
	logic [bfs_pkg::DATA_W-1:0] d;
	logic                       hs;
	logic                       ls;
	logic                       pg_oe;
	logic                       fixed;
	logic                       clamp;
	logic                       hs_off;
	logic                       ls_off;
	logic                       pwm;
	logic                       oc;
	logic                       slow;
	logic [7:0]                 duty;
	logic [1:0]                 oc_mode;
	logic                       hs_q = 1'b0;
	int                         fail_count;
	int                         compares;
	int                         hs_rises;
	int                         cyc;
	int                         t0;
	int                         seed;
	int                         exp_q[$] = '{4, 5, 6};

	always #5 clk_sys = ~clk_sys;

	// cycle count and high-side pulse starts
	always @(posedge clk_sys)
	begin
		cyc++;
		hs_q <= hs;
		if (hs && !hs_q)
			hs_rises++;
	end

	// the partner owns the switching flags
	always_comb
	begin
		pins = drv;
		pins.pwm_cmp = pwm;
		pins.hs_gate_off = hs_off;
		pins.ls_gate_off = ls_off;
		pins.lowside_overcurrent_detect = oc;
	end

	bfs_buck_fault_sequencer #(
		.SS_CYC_RESET(2)
	) u_bfs_buck_fault_sequencer (
		.clk_sys(clk_sys), .reset_n(reset_n), .pins_in(pins), .bus_req(bus),
		.rd_data(rd_data), .high_side_switch(hs), .low_side_switch(ls),
		.power_good_out_o(), .power_good_out_oe(pg_oe),
		.oc_threshold_fixed(fixed), .comp_clamp(clamp)
	);

	bfs_analog_model u_bfs_analog_model (
		.clk_sys(clk_sys), .high_side_switch(hs), .low_side_switch(ls),
		.slow(slow), .duty(duty), .oc_mode(oc_mode), .hs_gate_off(hs_off),
		.ls_gate_off(ls_off), .pwm_cmp(pwm), .lowside_overcurrent_detect(oc)
	);

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		bus.addr  <= a;
		bus.wdata <= v;
		bus.wr    <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// polls the status state field within a bound
	task automatic wait_state(input int s, input int lim);
		for (int i = 0; i < lim; i += 2)
		begin
			rd(2'h0);
			if (d[10:8] == s[2:0])
				break;
		end
		chk("state", 16'(s), 16'(d[10:8]));
	endtask

	// {high side, low side, power good pulled low, comp clamp}
	task automatic drives(input logic [3:0] e);
		chk("drives", 16'(e), 16'({hs, ls, pg_oe, clamp}));
	endtask

	task automatic wait_hs(input int lim);
		int r;
		r = hs_rises;
		for (int i = 0; i < lim && hs_rises == r; i++)
			@(posedge clk_sys);
		chk("hs_rise", 16'h1, 16'(hs_rises != r));
	endtask

	// one trip in the low-side part of a cycle, released before its end
	task automatic trip_once();
		@(posedge clk_sys);
		duty <= 8'(60 + {$random(seed)} % 60);
		slow <= 1'($random(seed));
		wait_hs(400);
		@(posedge clk_sys);
		oc_mode <= 2'h2;
		repeat (178) @(posedge clk_sys);
		rd(2'h0);
		chk("oc_skip", 16'h1, 16'(d[1]));
		@(posedge clk_sys);
		oc_mode <= 2'h0;
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the sequence needs roughly a third of this
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end

	initial
	begin
		seed = 32'h183d;
		drv = '0;
		drv.deep_disable = 1'b1;
		bus = '0;
		slow = 1'b0;
		duty = 8'd100;
		oc_mode = 2'h0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1 chk("reset", 16'h0004, {rd_data[10:0], hs, ls, pg_oe, fixed, clamp});
		rd(2'h1);
		chk("ss_len", 16'h0002, d);
		wr(2'h1, 16'h0003);
		wr(2'h0, 16'hffff);
		rd(2'h1);
		chk("ss_len", 16'(SS_RUN), d);
		rd(2'h2);
		chk("unmapped", 16'h0000, d);
		// enable while deep disabled, then one lockout at a time
		@(posedge clk_sys);
		drv.en_cmp <= 1'b1;
		repeat (50) @(posedge clk_sys);
		wait_state(0, 2);
		drives(4'b0010);
		@(posedge clk_sys);
		drv.deep_disable <= 1'b0;
		drv.vin_lockout <= 1'b1;
		repeat (50) @(posedge clk_sys);
		wait_state(0, 2);
		chk("oc_fixed", 16'h1, 16'(fixed));
		@(posedge clk_sys);
		drv.vin_lockout <= 1'b0;
		drv.vcc_lockout <= 1'b1;
		repeat (50) @(posedge clk_sys);
		wait_state(0, 2);
		// pre-biased start, with faults that soft-start ignores
		@(posedge clk_sys);
		drv.vcc_lockout <= 1'b0;
		drv.fb_above_reg <= 1'b1;
		{drv.fb_ov_cmp, drv.fb_uv_cmp, drv.external_overtemp_input,
			drv.internal_thermal_shutdown} <= 4'hf;
		t0 = hs_rises;
		wait_state(1, 20);
		repeat (700) @(posedge clk_sys);
		wait_state(1, 2);
		chk("prebias", 16'(t0), 16'(hs_rises));
		@(posedge clk_sys);
		drv.fb_above_reg <= 1'b0;
		drv.current_set_resistor_present <= 1'b1;
		{drv.fb_ov_cmp, drv.fb_uv_cmp, drv.external_overtemp_input,
			drv.internal_thermal_shutdown} <= 4'h0;
		wait_state(2, 1000);
		repeat (10) @(posedge clk_sys);
		#1 chk("pg_run", 16'h0, {14'h0, pg_oe, fixed});
		// overvoltage blanking and latch, undervoltage ends it
		@(posedge clk_sys);
		drv.fb_ov_cmp <= 1'b1;
		repeat (1900) @(posedge clk_sys);
		wait_state(2, 2);
		wait_state(3, 300);
		// dead time before the low side may follow a live high pulse
		repeat (12) @(posedge clk_sys);
		#1 drives(4'b0110);
		@(posedge clk_sys);
		drv.fb_ov_cmp <= 1'b0;
		drv.fb_uv_cmp <= 1'b1;
		wait_state(4, 20);
		drives(4'b0010);
		@(posedge clk_sys);
		drv.fb_uv_cmp <= 1'b0;
		t0 = cyc;
		wait_state(1, HIC + 400);
		chk("hiccup", 16'h1, 16'(cyc - t0 > HIC - 200 && cyc - t0 < HIC + 250));
		wait_state(2, 800);
		// undervoltage, external and internal overtemperature
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk_sys);
			{drv.fb_uv_cmp, drv.external_overtemp_input,
				drv.internal_thermal_shutdown} <= 3'b100 >> k;
			wait_state(exp_q[k], 2300);
			drives({3'b001, k == 2});
			@(posedge clk_sys);
			{drv.fb_uv_cmp, drv.external_overtemp_input,
				drv.internal_thermal_shutdown} <= 3'h0;
			wait_state(1, k == 0 ? HIC + 400 : 50);
			wait_state(2, 800);
		end
		// overcurrent: blanked trips, clearing, consecutive trips
		@(posedge clk_sys);
		oc_mode <= 2'h1;
		repeat (800) @(posedge clk_sys);
		rd(2'h0);
		chk("oc_blank", 16'h0, 16'({d[7:6], d[1]}));
		@(posedge clk_sys);
		oc_mode <= 2'h0;
		trip_once();
		wait_hs(300);
		trip_once();
		wait_hs(300);
		rd(2'h0);
		chk("oc_count", 16'h2, 16'(d[7:6]));
		repeat (9 * bfs_pkg::SW_CYC) @(posedge clk_sys);
		rd(2'h0);
		chk("oc_count", 16'h0, 16'(d[7:6]));
		for (int i = 0; i < 3; i++)
		begin
			trip_once();
			if (i < 2)
				repeat (800) @(posedge clk_sys);
		end
		wait_state(4, 400);
		drives(4'b0010);
		report_and_stop();
	end
endmodule
